// [src/fqd_pkg.sv]
`default_nettype none
package fqd_pkg;

  // Command opcodes, shifted in one bit per rising SCK edge on IO0
  localparam logic [7:0] FQD_OP_QUAD      = 8'h6B;  // quad_output_read_cmd
  localparam logic [7:0] FQD_OP_QUAD_WIDE = 8'h6C;  // quad_output_read_wide_addr_cmd
  localparam logic [7:0] FQD_OP_DUAL      = 8'hBB;  // dual_io_read_cmd
  localparam logic [7:0] FQD_OP_DUAL_WIDE = 8'hBC;  // dual_io_read_wide_addr_cmd

  // Phase lengths in bits
  localparam logic [5:0] FQD_OPCODE_LAST  = 6'h07;  // Index of the last opcode bit
  localparam logic [5:0] FQD_ADDR_NARROW  = 6'h18;  // 3-byte address
  localparam logic [5:0] FQD_ADDR_WIDE    = 6'h20;  // 4-byte address
  localparam logic [5:0] FQD_MODE_BITS    = 6'h08;  // Mode byte, two bits per edge
  localparam logic [5:0] FQD_STEP_QUAD    = 6'h01;  // Address bits per edge, quad read
  localparam logic [5:0] FQD_STEP_DUAL    = 6'h02;  // Address bits per edge, dual read

  // Mode upper nibble that keeps the opcode-free read mode alive
  localparam logic [3:0] FQD_MODE_CONT    = 4'hA;

  // Data path constants
  localparam logic [23:0] FQD_ADDR_RESET  = 24'h000000;
  localparam logic [23:0] FQD_ADDR_ONE    = 24'h000001;
  localparam logic [1:0]  FQD_UNITS_QUAD  = 2'h1;   // Last nibble index of a byte
  localparam logic [1:0]  FQD_UNITS_DUAL  = 2'h3;   // Last bit-pair index of a byte
  localparam logic [3:0]  FQD_OE_QUAD     = 4'hF;
  localparam logic [3:0]  FQD_OE_DUAL     = 4'h3;
  localparam logic [3:0]  FQD_OE_OFF      = 4'h0;

  // Register map, word indices on the plain register port
  localparam logic [3:0] FQD_REG_CTRL     = 4'h0;
  localparam logic [3:0] FQD_REG_STAT     = 4'h1;
  localparam logic [7:0] FQD_RDATA_ZERO   = 8'h00;

  // Control register layout: bit0 address width, bit1 quad enable, bits3:2 latency
  typedef struct packed {
    logic [1:0] latency_code;          // Dummy cycle selector
    logic       quad_enable;           // Gates the quad output read
    logic       address_width_select;  // Four-byte address for the narrow opcodes
  } fqd_cfg_s;

  localparam fqd_cfg_s FQD_CFG_RESET = 4'h0;

  // Sampled pin group
  typedef struct packed {
    logic       cs_n;
    logic       sck;
    logic [3:0] io;
  } fqd_pins_s;

  // Transaction phases, one-hot
  typedef enum logic [6:0] {
    FQD_ST_IDLE   = 7'h01,
    FQD_ST_OPCODE = 7'h02,
    FQD_ST_ADDR   = 7'h04,
    FQD_ST_MODE   = 7'h08,
    FQD_ST_DUMMY  = 7'h10,
    FQD_ST_DATA   = 7'h20,
    FQD_ST_IGNORE = 7'h40
  } fqd_state_e;

endpackage
`default_nettype wire

// [src/fqd_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module fqd_sync #(
  parameter int WIDTH = 6  // Number of independent levels to synchronise
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire logic [WIDTH-1:0] i_d,
  output var  logic [WIDTH-1:0] o_q
);

  logic [WIDTH-1:0] meta;  // First stage, read by the second stage only

  // Two flops per bit; pins are asynchronous to i_clk
  for (genvar g = 0; g < WIDTH; g++)
  begin : g_bit
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
      if (!i_rst_b)
      begin
        meta[g] <= 1'b0;
        o_q[g]  <= 1'b0;
      end
      else
      begin
        meta[g] <= i_d[g];
        o_q[g]  <= meta[g];
      end
    end
  end

endmodule // fqd_sync
`default_nettype wire

// [src/fqd_read_path.sv]
// Overview of operation
// - 6Bh address width follows select; 6Ch four bytes
// - BBh address width follows select; BCh four bytes
// - Quad data: four bits per falling edge
// - Quad: dummy cycles after address, inputs ignored
// - Dummy count chosen by latency code
// - Address increments per byte, wraps to zero
// - Quad read only when quad enable set
// - Dual address two bits per rising edge
// - Dual: opcode, address, mode, latency, data
// - Mode Axh: next frame starts with address
// - Only mode bits 7-4 decide continuation
// - Other mode value: leave at CS rise
// - Short frame without command leaves continuation
// - Dual data: two bits per falling edge
// - Dual dummy cycles: inputs ignored
// - Opcode one bit per rising edge
// - Select bit enables four-byte narrow opcodes
// - Address bits above A23 ignored
// - CS rise ends any read
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module fqd_read_path #(
  parameter logic [15:0] QUAD_DUMMY_TABLE = 16'h0888,  // Nibble per latency code
  parameter logic [15:0] DUAL_DUMMY_TABLE = 16'h0444   // Nibble per latency code
) (
  input  wire logic                i_clk,
  input  wire logic                i_rst_b,
  input  wire logic                i_sck,
  input  wire logic                i_cs_n,
  input  wire logic [3:0]          i_io,
  output var  logic [3:0]          o_io,
  output var  logic [3:0]          o_io_oe,
  output var  logic [23:0]         o_mem_addr,
  input  wire logic [7:0]          i_mem_data,
  input  wire logic [3:0]          i_reg_addr,
  input  wire logic [7:0]          i_reg_wdata,
  input  wire logic                i_reg_wr,
  input  wire logic                i_reg_rd,
  output var  logic [7:0]          o_reg_rdata,
  output var  fqd_pkg::fqd_cfg_s   o_cfg
);
  import fqd_pkg::*;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  fqd_pins_s  pin_raw;        // Raw pin group
  fqd_pins_s  pin_q;          // Pins after two flops
  logic       sck_d;          // Previous synchronised SCK
  logic       cs_n_d;         // Previous synchronised CS#
  fqd_state_e state;          // Current phase
  fqd_state_e next_state;
  logic [5:0] bit_cnt;        // Bits taken in the current phase
  logic [5:0] next_bit_cnt;
  logic [7:0] opcode;         // Opcode shift register
  logic [7:0] next_opcode;
  logic [23:0] addr;          // Byte address, upper bits fall off
  logic [23:0] next_addr;
  logic [7:0] mode;           // Captured mode byte
  logic [7:0] next_mode;
  logic       mode_done;      // Full mode byte seen in this frame
  logic       next_mode_done;
  logic       cmd_quad;       // Current read is the quad output read
  logic       next_cmd_quad;
  logic       cmd_wide;       // Current read takes four address bytes
  logic       next_cmd_wide;
  logic       cont;           // Opcode-free read mode armed
  logic       next_cont;
  logic       cont_wide;      // Address width for the opcode-free read
  logic       next_cont_wide;
  logic [3:0] dummy_cnt;      // Falling edges left before data
  logic [3:0] next_dummy_cnt;
  logic [1:0] unit;           // Nibble or bit-pair index in the byte
  logic [1:0] next_unit;
  logic [7:0] data_sh;        // Remaining bits of the byte on the wire
  logic [7:0] next_data_sh;
  logic [3:0] next_io;
  logic [3:0] next_io_oe;

  assign pin_raw = {i_cs_n, i_sck, i_io};

  // Every pin passes two flops before any logic looks at it
  fqd_sync #(
    .WIDTH ($bits(fqd_pins_s))
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_d     (pin_raw),
    .o_q     (pin_q)
  );

  // Edge detection on the synchronised link clock and select
  wire sck_rise = pin_q.sck & ~sck_d;
  wire sck_fall = ~pin_q.sck & sck_d;
  wire cs_fall  = ~pin_q.cs_n & cs_n_d;
  wire cs_rise  = pin_q.cs_n & ~cs_n_d;

  // Phase decodes
  wire st_opcode = (state == FQD_ST_OPCODE);
  wire st_addr   = (state == FQD_ST_ADDR);
  wire st_mode   = (state == FQD_ST_MODE);
  wire st_dummy  = (state == FQD_ST_DUMMY);
  wire st_data   = (state == FQD_ST_DATA);

  // Opcode decode on the byte including the bit arriving now
  wire [7:0] op_full    = {opcode[6:0], pin_q.io[0]};
  wire       op_quad    = (op_full == FQD_OP_QUAD) | (op_full == FQD_OP_QUAD_WIDE);
  wire       op_dual    = (op_full == FQD_OP_DUAL) | (op_full == FQD_OP_DUAL_WIDE);
  wire       op_accept  = op_quad & o_cfg.quad_enable;
  // Wide opcodes always four bytes, narrow ones follow the select bit
  wire       op_wide    = (op_full == FQD_OP_QUAD_WIDE) | (op_full == FQD_OP_DUAL_WIDE)
                          | o_cfg.address_width_select;
  wire       opcode_end = st_opcode & sck_rise & (bit_cnt == FQD_OPCODE_LAST);

  // Address shifting: one bit on IO0 for quad, IO1:IO0 for dual
  wire [5:0]  addr_step  = cmd_quad ? FQD_STEP_QUAD : FQD_STEP_DUAL;
  wire [5:0]  addr_sum   = bit_cnt + addr_step;
  wire [5:0]  addr_bits  = cmd_wide ? FQD_ADDR_WIDE : FQD_ADDR_NARROW;
  wire        addr_end   = (addr_sum == addr_bits);
  // Only 24 bits are kept, so A31..A24 of a wide address drop out
  wire [23:0] addr_shift = cmd_quad ? {addr[22:0], pin_q.io[0]}
                                    : {addr[21:0], pin_q.io[1:0]};

  // Mode capture, two bits per rising edge
  wire [7:0] mode_shift = {mode[5:0], pin_q.io[1:0]};
  wire [5:0] mode_sum   = bit_cnt + FQD_STEP_DUAL;
  wire       mode_end   = (mode_sum == FQD_MODE_BITS);
  // Low nibble is never looked at; it may be floating on the wire
  wire       mode_keeps = mode_done & (mode[7:4] == FQD_MODE_CONT);

  // Dummy length from the latency code
  wire [3:0] quad_dummy = QUAD_DUMMY_TABLE[{o_cfg.latency_code, 2'b00} +: 4];
  wire [3:0] dual_dummy = DUAL_DUMMY_TABLE[{o_cfg.latency_code, 2'b00} +: 4];

  // Data drive: first unit after the dummy count runs out, then every fall
  wire       drive      = sck_fall & (st_data | (st_dummy & (dummy_cnt == 4'h0)));
  wire [1:0] unit_last  = cmd_quad ? FQD_UNITS_QUAD : FQD_UNITS_DUAL;
  wire       byte_end   = (unit == unit_last);
  wire [7:0] byte_src   = (unit == 2'h0) ? i_mem_data : data_sh;
  wire [3:0] drive_io   = cmd_quad ? byte_src[7:4] : {2'b00, byte_src[7:6]};
  wire [7:0] drive_sh   = cmd_quad ? {byte_src[3:0], 4'h0} : {byte_src[5:0], 2'b00};

  // Register port decodes
  wire       wr_ctrl    = i_reg_wr & (i_reg_addr == FQD_REG_CTRL);
  wire [7:0] stat_word  = {cont, state};
  wire [7:0] rd_mux     = (i_reg_addr == FQD_REG_CTRL) ? {4'h0, o_cfg}
                        : (i_reg_addr == FQD_REG_STAT) ? stat_word
                        : FQD_RDATA_ZERO;

  // Next-state logic for the link side
  always_comb
  begin
    next_state     = state;
    next_bit_cnt   = bit_cnt;
    next_opcode    = opcode;
    next_addr      = addr;
    next_mode      = mode;
    next_mode_done = mode_done;
    next_cmd_quad  = cmd_quad;
    next_cmd_wide  = cmd_wide;
    next_cont      = cont;
    next_cont_wide = cont_wide;
    next_dummy_cnt = dummy_cnt;
    next_unit      = unit;
    next_data_sh   = data_sh;
    next_io        = o_io;
    next_io_oe     = o_io_oe;
    if (cs_rise)
    begin
      // Frame over wherever it stood; continuation kept only on Axh
      next_state = FQD_ST_IDLE;
      next_io_oe = FQD_OE_OFF;
      // A short frame never completes a mode byte, so it also disarms
      next_cont  = mode_keeps;
    end
    else if (cs_fall)
    begin
      next_bit_cnt   = 6'h00;
      next_mode_done = 1'b0;
      next_unit      = 2'h0;
      if (cont)
      begin
        // Opcode-free frame: straight into a dual address
        next_state    = FQD_ST_ADDR;
        next_cmd_quad = 1'b0;
        next_cmd_wide = cont_wide;
      end
      else
      begin
        next_state = FQD_ST_OPCODE;
      end
    end
    else
    begin
      case (state)
        FQD_ST_OPCODE:
        begin
          if (sck_rise)
          begin
            next_opcode  = op_full;
            next_bit_cnt = bit_cnt + 6'h01;
            if (opcode_end)
            begin
              next_bit_cnt  = 6'h00;
              next_cmd_quad = op_accept;
              next_cmd_wide = op_wide;
              // Unknown command, or quad while disabled: sit out the frame
              next_state    = (op_accept | op_dual) ? FQD_ST_ADDR : FQD_ST_IGNORE;
            end
          end
        end
        FQD_ST_ADDR:
        begin
          if (sck_rise)
          begin
            next_addr    = addr_shift;
            next_bit_cnt = addr_sum;
            if (addr_end)
            begin
              next_bit_cnt = 6'h00;
              // Quad goes to its latency, dual first takes the mode byte
              if (cmd_quad)
              begin
                next_state     = FQD_ST_DUMMY;
                next_dummy_cnt = quad_dummy;
              end
              else
              begin
                next_state = FQD_ST_MODE;
              end
            end
          end
        end
        FQD_ST_MODE:
        begin
          if (sck_rise)
          begin
            next_mode    = mode_shift;
            next_bit_cnt = mode_sum;
            if (mode_end)
            begin
              next_mode_done = 1'b1;
              next_cont_wide = cmd_wide;
              next_state     = FQD_ST_DUMMY;
              next_dummy_cnt = dual_dummy;
            end
          end
        end
        FQD_ST_DUMMY:
        begin
          // Inputs are not sampled here at all, so floating lines are harmless
          if (sck_fall)
          begin
            if (dummy_cnt == 4'h0)
            begin
              next_state = FQD_ST_DATA;
            end
            else
            begin
              next_dummy_cnt = dummy_cnt - 4'h1;
            end
          end
        end
        FQD_ST_DATA:
        begin
          // Output work is done below; the phase lasts until CS# rises
        end
        FQD_ST_IDLE, FQD_ST_IGNORE:
        begin
          // Wait for the next select edge
        end
        default:
        begin
          next_state = FQD_ST_IDLE;
        end
      endcase
      // Shift one unit onto the lines on each falling edge of the data phase
      if (drive)
      begin
        next_io      = drive_io;
        next_io_oe   = cmd_quad ? FQD_OE_QUAD : FQD_OE_DUAL;
        next_data_sh = drive_sh;
        next_unit    = byte_end ? 2'h0 : unit + 2'h1;
        if (byte_end)
        begin
          // 24-bit counter rolls from the top straight to zero
          next_addr = addr + FQD_ADDR_ONE;
        end
      end
    end
  end

  // Pin history for edge detection
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      sck_d  <= 1'b0;
      // Matches the synchroniser's low reset output, so release shows no false fall;
      // a frame already running at release then waits for its CS# rise
      cs_n_d <= 1'b0;
    end
    else
    begin
      sck_d  <= pin_q.sck;
      cs_n_d <= pin_q.cs_n;
    end
  end

  // Phase and control flops
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state     <= FQD_ST_IDLE;
      bit_cnt   <= 6'h00;
      opcode    <= 8'h00;
      mode      <= 8'h00;
      mode_done <= 1'b0;
      cmd_quad  <= 1'b0;
      cmd_wide  <= 1'b0;
      cont      <= 1'b0;
      cont_wide <= 1'b0;
      dummy_cnt <= 4'h0;
    end
    else
    begin
      state     <= next_state;
      bit_cnt   <= next_bit_cnt;
      opcode    <= next_opcode;
      mode      <= next_mode;
      mode_done <= next_mode_done;
      cmd_quad  <= next_cmd_quad;
      cmd_wide  <= next_cmd_wide;
      cont      <= next_cont;
      cont_wide <= next_cont_wide;
      dummy_cnt <= next_dummy_cnt;
    end
  end

  // Data path flops; the array address is a flop so memory sees a clean value
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      addr    <= FQD_ADDR_RESET;
      unit    <= 2'h0;
      data_sh <= 8'h00;
      o_io    <= 4'h0;
      o_io_oe <= FQD_OE_OFF;
    end
    else
    begin
      addr    <= next_addr;
      unit    <= next_unit;
      data_sh <= next_data_sh;
      o_io    <= next_io;
      o_io_oe <= next_io_oe;
    end
  end

  assign o_mem_addr = addr;

  // Register port; changing the control word mid-frame takes effect at once
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_cfg       <= FQD_CFG_RESET;
      o_reg_rdata <= FQD_RDATA_ZERO;
    end
    else
    begin
      if (wr_ctrl)
      begin
        o_cfg <= i_reg_wdata[3:0];
      end
      o_reg_rdata <= i_reg_rd ? rd_mux : FQD_RDATA_ZERO;
    end
  end

  // Checks
  drivers_data_a: assert property (o_io_oe != FQD_OE_OFF |-> st_data)
    else $error("IO drivers on outside the data phase");
  quad_width_a: assert property (st_data && cmd_quad |-> o_io_oe == FQD_OE_QUAD)
    else $error("Quad data phase not driving four lines");
  dual_width_a: assert property (st_data && !cmd_quad |-> o_io_oe == FQD_OE_DUAL)
    else $error("Dual data phase not driving two lines");
  io_on_fall_a: assert property ($changed(o_io) |-> $past(sck_fall))
    else $error("Output data changed away from a falling SCK edge");
  cs_ends_a: assert property (cs_rise |=> state == FQD_ST_IDLE && o_io_oe == FQD_OE_OFF)
    else $error("Read not ended by CS rise");
  cont_keep_a: assert property (cs_rise |=> cont == $past(mode_keeps))
    else $error("Continuation flag wrong after CS rise");
  cont_entry_a: assert property (cs_fall && cont && !cs_rise |=> st_addr && !cmd_quad)
    else $error("Opcode-free frame did not start in address phase");
  quad_gate_a: assert property (opcode_end && op_quad && !o_cfg.quad_enable && !cs_rise
                                |=> state == FQD_ST_IGNORE)
    else $error("Quad read accepted while quad disabled");
  addr_wrap_a: assert property (drive && byte_end && addr == 24'hFFFFFF
                                && !cs_rise && !cs_fall |=> addr == FQD_ADDR_RESET)
    else $error("Address did not wrap to zero");
  dummy_hold_a: assert property (st_dummy && dummy_cnt != 4'h0 |-> o_io_oe == FQD_OE_OFF)
    else $error("Drivers on during dummy cycles");

  quad_data_c: cover property (st_data && cmd_quad);
  dual_data_c: cover property (st_data && !cmd_quad && mode_done);
  cont_frame_c: cover property (cs_fall && cont);
  wrap_c: cover property (drive && byte_end && addr == 24'hFFFFFF);

endmodule // fqd_read_path
`default_nettype wire

// [verif/fqd_host.sv]
`timescale 1ns/100ps
`default_nettype none
module fqd_host (
  input  wire logic       i_clk,
  input  wire logic [3:0] i_io,
  output var  logic       o_sck,
  output var  logic       o_cs_n,
  output var  logic [3:0] o_io,
  output var  logic       o_oe,
  output var  logic       o_data
);
  logic [7:0] got [8];  // Bytes read back

  // Idle bus: SCK low, CS high
  initial
  begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_io = 4'h0;
    o_oe = 1'b0;
    o_data = 1'b0;
  end

  // One SCK period of 32 clocks; host samples at the rise
  task automatic cyc(output logic [3:0] s);
    repeat (16) @(posedge i_clk);
    o_sck <= 1'b1;
    s = i_io;
    repeat (16) @(posedge i_clk);
    o_sck <= 1'b0;
  endtask

  // Mode 0 frame; CS stays low through mode and dummy
  task automatic frame(input bit op_on, input logic [7:0] op,
                       input logic [31:0] a, input int aw, input bit dual,
                       input logic [7:0] md, input int nd, input int nb);
    logic [3:0] s;
    logic [7:0] v;
    int         i;
    int         u;
    u = dual ? 4 : 2;
    v = 8'h00;
    o_cs_n <= 1'b0;
    o_oe <= 1'b1;
    // Opcode MSB first on IO0
    if (op_on)
      for (i = 7; i >= 0; i--)
      begin
        o_io <= {3'h0, op[i]};
        cyc(s);
      end
    // Address, one or two bits per rise
    for (i = aw - 1; i >= 0; i -= u / 2)
    begin
      if (dual)
        o_io <= {2'h0, a[i-:2]};
      else
        o_io <= {3'h0, a[i]};
      cyc(s);
    end
    // Low mode nibble left floating to give the bus time to turn
    for (i = 0; i < 4 && dual && nb > 0; i++)
    begin
      o_io <= {2'h0, md[7-2*i-:2]};
      o_oe <= (i < 2);
      cyc(s);
    end
    o_oe <= 1'b0;
    repeat (nd) cyc(s);
    o_data <= 1'b1;
    // Data, high part of each byte first
    for (i = 0; i < nb * u; i++)
    begin
      cyc(s);
      v = dual ? {v[5:0], s[1:0]} : {v[3:0], s};
      if (i % u == u - 1)
        got[i / u] = v;
    end
  endtask

  // End the frame; the data flag lingers while drivers turn off
  task automatic stop();
    repeat (16) @(posedge i_clk);
    o_cs_n <= 1'b1;
    repeat (8) @(posedge i_clk);
    o_data <= 1'b0;
    repeat (40) @(posedge i_clk);
  endtask
endmodule  // fqd_host
`default_nettype wire

// [verif/fqd_read_path_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module fqd_read_path_tb;
  import fqd_pkg::*;
  logic        clk;
  logic        rst_b;
  logic        sck;
  logic        cs_n;
  logic [3:0]  io_w;         // Resolved IO lines
  logic [3:0]  dev_io;
  logic [3:0]  dev_oe;
  logic [3:0]  host_io;
  logic        host_oe;
  logic        in_data;
  logic        flt = 1'b0;   // Released lines toggle every clock
  logic [23:0] mem_addr;
  logic [7:0]  mem_data;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  fqd_cfg_s    cfg;
  logic [7:0]  v;
  int          fails = 0;
  int          check_count = 0;
  int          early = 0;    // Drive cycles outside data

  fqd_read_path i_fqd_read_path (
    .i_clk(clk), .i_rst_b(rst_b), .i_sck(sck), .i_cs_n(cs_n),
    .i_io(io_w), .o_io(dev_io), .o_io_oe(dev_oe),
    .o_mem_addr(mem_addr), .i_mem_data(mem_data),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .o_cfg(cfg));

  fqd_host i_fqd_host (
    .i_clk(clk), .i_io(io_w), .o_sck(sck), .o_cs_n(cs_n),
    .o_io(host_io), .o_oe(host_oe), .o_data(in_data));

  // Array contents are a hash of the address
  function automatic logic [7:0] mem_byte(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3C;
  endfunction
  assign mem_data = mem_byte(mem_addr);
  // Device wins where it drives; nobody driving means noise
  assign io_w = (dev_oe & dev_io) | (~dev_oe & (host_oe ? host_io : {4{flt}}));

  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Noise source and early-drive monitor
  always_ff @(posedge clk)
  begin
    flt <= ~flt;
    if (dev_oe !== 4'h0 && !in_data)
      early <= early + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr_t(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_rd_t(input logic [3:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask

  // One frame, then drive and byte checks
  task automatic run(input bit op_on, input logic [7:0] op, input logic [31:0] a,
                     input int aw, input bit dual, input logic [7:0] md,
                     input int nd, input int nb, input logic [3:0] oe);
    i_fqd_host.frame(op_on, op, a, aw, dual, md, nd, nb);
    check(dev_oe, oe);
    i_fqd_host.stop();
    check(dev_oe, FQD_OE_OFF);
    for (int b = 0; b < nb && oe != FQD_OE_OFF; b++)
      check(i_fqd_host.got[b], mem_byte(a[23:0] + 24'(b)));
  endtask

  task automatic stop_test();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    rst_b = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    check(cfg, FQD_CFG_RESET);
    reg_wr_t(4'h3, 8'h0F);
    reg_rd_t(FQD_REG_CTRL, v);
    check(v[3:0], 4'h0);
    reg_rd_t(4'h5, v);
    check(v, FQD_RDATA_ZERO);
    run(1, FQD_OP_QUAD, 32'h10, 24, 0, 8'h00, 8, 2, FQD_OE_OFF);
    reg_wr_t(FQD_REG_CTRL, 8'h02);
    reg_rd_t(FQD_REG_CTRL, v);
    check(v[3:0], 4'h2);
    run(1, FQD_OP_QUAD, 32'h123456, 24, 0, 8'h00, 8, 3, FQD_OE_QUAD);
    run(1, FQD_OP_QUAD_WIDE, 32'hABFFFFFE, 32, 0, 8'h00, 8, 3, FQD_OE_QUAD);
    reg_wr_t(FQD_REG_CTRL, 8'h0F);
    run(1, FQD_OP_QUAD, 32'hC0000100, 32, 0, 8'h00, 0, 2, FQD_OE_QUAD);
    reg_wr_t(FQD_REG_CTRL, 8'h08);
    run(1, FQD_OP_DUAL, 32'hF0, 24, 1, 8'hA5, 4, 2, FQD_OE_DUAL);
    reg_rd_t(FQD_REG_STAT, v);
    check(v, {1'b1, FQD_ST_IDLE});
    run(0, 8'h00, 32'h200, 24, 1, 8'h30, 4, 2, FQD_OE_DUAL);
    reg_rd_t(FQD_REG_STAT, v);
    check(v, {1'b0, FQD_ST_IDLE});
    run(1, FQD_OP_DUAL_WIDE, 32'hFF000300, 32, 1, 8'hA0, 4, 2, FQD_OE_DUAL);
    run(0, 8'h00, 32'h0, 8, 1, 8'h00, 0, 0, FQD_OE_OFF);
    reg_rd_t(FQD_REG_STAT, v);
    check(v, {1'b0, FQD_ST_IDLE});
    run(1, FQD_OP_DUAL, 32'hFF, 24, 1, 8'h00, 4, 1, FQD_OE_DUAL);
    check(early, 0);
    stop_test();
  end

  // Watchdog: the whole run needs about 11000 clocks
  initial
  begin
    repeat (60000) @(posedge clk);
    fails++;
    stop_test();
  end
endmodule  // fqd_read_path_tb
`default_nettype wire
